// >>> dbic_dma_ctrl.sv
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
// dma burst and interrupt control with wishbone register slave
module dbic_dma_ctrl
  import dbic_pkg::*;
#(
  parameter int DEAD_CYCLES = DEAD_DEFAULT  // burst dead-time in clocks
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // host bus pins
  input  wire logic        ssyn,
  output logic             msyn,
  output logic             bbsy,
  output logic             sack,
  output logic             irq,
  // user side pins
  input  wire logic [15:0] dataWord,
  input  wire logic        cycleRequest,
  input  wire logic        singleCycle,
  input  wire logic        userAttention,
  input  wire logic        powerFailLow,
  input  wire logic        parityError,
  output logic             nCycleIndicator
);
  // ****************************************
  // synchronised pins
  // ****************************************
  dbic_pin_if pinBus ();
  assign pinBus.raw = {powerFailLow, userAttention, singleCycle, cycleRequest, ssyn, dataWord};
  dbic_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pins    (pinBus.syncer)
  );
  logic        ssynS;      // synced ssyn
  logic        cycRqS;     // synced cycle_request
  logic        singleS;    // synced single-cycle hold
  logic        attnS;      // synced attention
  logic        powerS;     // synced power fail
  logic [15:0] dataS;      // synced data word
  logic        parityS1;   // parity first stage
  logic        parityS;    // parity second stage
  logic        cycRqPrev;  // for edge detect
  assign ssynS   = pinBus.sync[PIN_SSYN];
  assign cycRqS  = pinBus.sync[PIN_CYCRQ];
  assign singleS = pinBus.sync[PIN_SINGLE];
  assign attnS   = pinBus.sync[PIN_USER_ATTENTION];
  assign powerS  = pinBus.sync[PIN_POWER];
  assign dataS   = pinBus.sync[15:0];

  // parity pin kept outside bundle, own two flops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      parityS1  <= 1'b0;
      parityS   <= 1'b0;
      cycRqPrev <= 1'b0;
    end else begin
      parityS1  <= parityError;
      parityS   <= parityS1;
      cycRqPrev <= cycRqS;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic             irqEnable;     // interrupt_enable
  logic             burstMode;     // burst on
  logic             twoCycle;      // two-cycle burst
  logic             infoSelect;    // error_info_select
  logic [ERR_W-1:0] errStatus;     // sticky errors
  logic [ERR_W-1:0] errMask;       // interrupt mask
  logic [15:0]      lastWord;      // output_data_holding
  logic             busWrite;      // accepted write
  logic             startPulse;    // start command
  logic [ERR_W-1:0] errSet;        // events this cycle
  logic             access;        // new bus request
  assign access     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign busWrite   = access && wb_we_i;
  assign startPulse = busWrite && wb_adr_i == ADR_CONTROL && wb_sel_i[0] && wb_dat_i[CTL_START];

  // wishbone ack, one cycle after request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) wb_ack_o <= 1'b0;
    else         wb_ack_o <= access;
  end

  // control and mask register writes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqEnable  <= 1'b0;
      burstMode  <= 1'b0;
      twoCycle   <= 1'b0;
      infoSelect <= 1'b0;
      errMask    <= MASK_RESET;
    end else if (busWrite) begin
      if (wb_adr_i == ADR_CONTROL && wb_sel_i[0]) begin
        irqEnable <= wb_dat_i[CTL_IRQ_EN];
        burstMode <= wb_dat_i[CTL_BURST];
        twoCycle  <= wb_dat_i[CTL_TWO_CYCLE];
      end
      if (wb_adr_i == ADR_CONTROL && wb_sel_i[1]) infoSelect <= wb_dat_i[CTL_INFO_SEL];
      if (wb_adr_i == ADR_MASK && wb_sel_i[0])    errMask    <= wb_dat_i[ERR_W-1:0];
    end
  end

  // sticky errors: set wins over start clear and write-one clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      errStatus <= '0;
    end else if (startPulse) begin
      errStatus <= errSet;
    end else if (busWrite && wb_adr_i == ADR_STATUS && wb_sel_i[0]) begin
      errStatus <= (errStatus & ~wb_dat_i[ERR_W-1:0]) | errSet;
    end else begin
      errStatus <= errStatus | errSet;
    end
  end

  // interrupt request, registered
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) irq <= 1'b0;
    else         irq <= irqEnable && |(errStatus & errMask);
  end

  // read data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_dat_o <= '0;
    end else if (access && !wb_we_i) begin
      unique case (wb_adr_i)
        ADR_CONTROL:  wb_dat_o <= {16'h0000, infoSelect, 11'h000, twoCycle, burstMode, irqEnable, 1'b0};
        ADR_STATUS:   wb_dat_o <= {27'h0000000, errStatus};
        ADR_MASK:     wb_dat_o <= {27'h0000000, errMask};
        ADR_LASTWORD: wb_dat_o <= infoSelect ? {16'h0000, lastWord} : 32'h00000000;
        default:      wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // transfer sequencer
  // ****************************************
  dbic_state_type state;
  logic [9:0]  nexCount;     // ssyn wait counter
  logic [31:0] deadCount;    // burst gap counter
  logic        cycleIndex;   // second cycle of two-cycle burst
  logic        thisLast;     // current cycle ends block
  logic        cycleLast;    // end decision held through the cycle
  logic        cycRqRise;    // new cycle request
  logic        nexExpired;   // ssyn timeout
  logic        deadExpired;  // gap timeout
  assign cycRqRise   = cycRqS && !cycRqPrev;
  assign nexExpired  = state == ST_CYCLE && nexCount == 10'(NEX_CYCLES - 1);
  assign deadExpired = state == ST_GAP && deadCount == 32'(DEAD_CYCLES - 1);
  // last cycle decided at start: single, attention, second of two, or hold dropped
  assign thisLast = !burstMode || attnS || (twoCycle ? cycleIndex : !singleS);

  // error events
  always_comb begin
    errSet             = '0;
    errSet[ERR_NEX]    = nexExpired;
    errSet[ERR_USER_ATTENTION]   = attnS;
    errSet[ERR_MULTI]  = state == ST_CYCLE && cycRqRise;
    errSet[ERR_POWER]  = powerS && state != ST_IDLE;
    errSet[ERR_PARITY] = parityS && state != ST_IDLE;
  end

  // state and bus pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= ST_IDLE;
      msyn       <= 1'b0;
      bbsy       <= 1'b0;
      sack       <= 1'b0;
      cycleIndex <= 1'b0;
      cycleLast  <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (startPulse) state <= ST_ARMED;
        end
        ST_ARMED, ST_GAP: begin
          // no new master sync until the old slave sync has cleared
          if (cycRqS && !ssynS) begin
            state     <= ST_CYCLE;
            bbsy      <= 1'b1;
            msyn      <= 1'b1;
            sack      <= !thisLast;
            cycleLast <= thisLast;
          end else if (deadExpired) begin
            state <= ST_IDLE;
            bbsy  <= 1'b0;
            sack  <= 1'b0;
          end
        end
        ST_CYCLE: begin
          if (ssynS || nexExpired) begin
            msyn       <= 1'b0;
            cycleIndex <= !cycleIndex;
            // end as decided at start; attention ends after this cycle
            if (cycleLast || attnS || nexExpired) begin
              state      <= ST_IDLE;
              bbsy       <= 1'b0;
              sack       <= 1'b0;
              cycleIndex <= 1'b0;
            end else begin
              state <= ST_GAP;
            end
          end
        end
      endcase
    end
  end

  // counters and last word latch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nexCount  <= '0;
      deadCount <= '0;
      lastWord  <= '0;
    end else begin
      nexCount  <= (state == ST_CYCLE && !ssynS) ? nexCount + 10'h001 : 10'h000;
      deadCount <= (state == ST_GAP && !cycRqS) ? deadCount + 32'h00000001 : 32'h00000000;
      if (state == ST_CYCLE && ssynS) lastWord <= dataS;
    end
  end

  // n-cycle indicator
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) nCycleIndicator <= 1'b0;
    else         nCycleIndicator <= burstMode && !twoCycle && state != ST_IDLE;
  end

  // ****************************************
  // checks
  // ****************************************
  chk_irq_cause: assert property (@(posedge clk) disable iff (sys_rst)
    irq |-> $past(irqEnable && |(errStatus & errMask))) else $error("irq without enabled error");
  chk_word_latch: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_CYCLE && ssynS) |=> lastWord == $past(dataS)) else $error("last word not latched");
  chk_dead_release: assert property (@(posedge clk) disable iff (sys_rst)
    (deadExpired && !cycRqS) |=> !bbsy && !sack && state == ST_IDLE) else $error("gap did not release");
  chk_two_cycle: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_CYCLE && burstMode && twoCycle && cycleIndex && ssynS) |=> state == ST_IDLE && !bbsy && !sack)
    else $error("two-cycle overrun");
  chk_led_mode: assert property (@(posedge clk) disable iff (sys_rst)
    nCycleIndicator |-> $past(burstMode && !twoCycle && state != ST_IDLE)) else $error("indicator wrong");
  chk_sack_last: assert property (@(posedge clk) disable iff (sys_rst)
    (state != ST_CYCLE ##1 state == ST_CYCLE) |-> sack == $past(!thisLast)) else $error("sack wrong at cycle");
  chk_nex_timeout: assert property (@(posedge clk) disable iff (sys_rst)
    nexExpired |=> errStatus[ERR_NEX] && !msyn) else $error("nex not flagged");
  chk_start_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (startPulse && errSet == '0) |=> errStatus == '0) else $error("start did not clear");
  chk_dead_count: assert property (@(posedge clk) disable iff (sys_rst)
    state == ST_GAP |-> deadCount < 32'(DEAD_CYCLES)) else $error("dead count overrun");
  cov_burst: cover property (@(posedge clk) disable iff (sys_rst) state == ST_GAP ##[1:50] state == ST_CYCLE);
  cov_dead: cover property (@(posedge clk) disable iff (sys_rst) deadExpired);
  cov_nex: cover property (@(posedge clk) disable iff (sys_rst) nexExpired);
endmodule
`default_nettype wire

// >>> dbic_pkg.sv
// Summary of operation
// - enabled error events raise bus interrupt request
// - latch last output word, read back when selected
// - burst dead-time expiry releases bus unless a new cycle starts on that clock
// - indicator output high in N-cycle burst
// - hold sack until last cycle, then negate
// - no ssyn within 13 us flags nonexistent memory
// - start command clears all latched errors
`default_nettype none
package dbic_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADR_CONTROL  = 8'h00;  // control word
  localparam logic [7:0] ADR_STATUS   = 8'h04;  // sticky errors, write one to clear
  localparam logic [7:0] ADR_MASK     = 8'h08;  // interrupt mask
  localparam logic [7:0] ADR_LASTWORD = 8'h0C;  // latched last output word
  // ****************************************
  // control bit positions
  // ****************************************
  localparam int CTL_START     = 0;   // write-only start pulse
  localparam int CTL_IRQ_EN    = 1;   // interrupt_enable
  localparam int CTL_BURST     = 2;   // burst mode
  localparam int CTL_TWO_CYCLE = 3;   // two-cycle burst when set
  localparam int CTL_INFO_SEL  = 15;  // error_info_select
  localparam int ERR_W         = 5;   // number of error bits
  localparam int ERR_NEX       = 0;   // nonexistent_memory_error
  localparam int ERR_USER_ATTENTION      = 1;   // user_attention
  localparam int ERR_MULTI     = 2;   // multi_cycle_request_error
  localparam int ERR_POWER     = 3;   // power_fail_low
  localparam int ERR_PARITY    = 4;   // parity_error
  localparam logic [ERR_W-1:0] MASK_RESET = 5'h1F;  // all unmasked
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ        = 40;                  // clock rate
  localparam int NEX_TIMEOUT_US = 13;                  // ssyn wait limit
  localparam int NEX_CYCLES     = NEX_TIMEOUT_US * CLK_MHZ;  // exact product, no rounding
  localparam int DEAD_DEFAULT   = 400;                 // default dead-time cycles
  // ****************************************
  // pin bundle layout
  // ****************************************
  localparam int PIN_W      = 21;  // data 16 plus five controls
  localparam int PIN_SSYN   = 16;
  localparam int PIN_CYCRQ  = 17;
  localparam int PIN_SINGLE = 18;
  localparam int PIN_USER_ATTENTION   = 19;
  localparam int PIN_POWER  = 20;
  typedef enum {ST_IDLE, ST_ARMED, ST_CYCLE, ST_GAP} dbic_state_type;
endpackage
`default_nettype wire

// >>> dbic_pin_if.sv
`timescale 1ns/100ps
`default_nettype none
// raw pins in, synchronised copy out
interface dbic_pin_if;
  import dbic_pkg::*;
  logic [PIN_W-1:0] raw;   // from pins
  logic [PIN_W-1:0] sync;  // two flops later
  modport syncer (input raw, output sync);
  modport user   (output raw, input sync);
endinterface
`default_nettype wire

// >>> dbic_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser for the pin bundle
module dbic_sync
  import dbic_pkg::*;
(
  // clock and reset
  input wire logic   clk,
  input wire logic   sys_rst,
  // bundle
  dbic_pin_if.syncer pins
);
  logic [PIN_W-1:0] stage1;  // read only by the second stage

  // ****************************************
  // double flop
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1    <= '0;
      pins.sync <= '0;
    end else begin
      stage1    <= pins.raw;
      pins.sync <= stage1;
    end
  end
endmodule
`default_nettype wire

// >>> dbic_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// host memory answering master sync
// ****************************************
module dbic_mem_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sysRst,
  // host bus
  input  wire logic       msyn,
  output logic            ssyn,
  // behaviour
  input  wire logic [7:0] delay,   // clocks before answering
  input  wire logic       silent   // never answer: absent memory
);
  logic [7:0] waitCnt;  // clocks since sync seen
  // answer after delay, drop as soon as sync goes
  always_ff @(posedge clk or posedge sysRst) begin
    if (sysRst) begin
      waitCnt <= 8'h00;
      ssyn    <= 1'b0;
    end else if (!msyn) begin
      waitCnt <= 8'h00;
      ssyn    <= 1'b0;
    end else begin
      if (waitCnt != 8'hFF) waitCnt <= waitCnt + 8'h01;
      ssyn <= !silent && (waitCnt >= delay);
    end
  end
endmodule
`default_nettype wire

// >>> dbic_dma_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin errTotal++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
module dbic_dma_ctrl_tb;
  import dbic_pkg::*;
  localparam int DEAD = 20;  // short dead-time for sim
  // ****************************************
  // signals
  // ****************************************
  logic        clk = 0, sysRst = 1;
  logic        wbCyc = 0, wbStb = 0, wbWe = 0, wbAck;
  logic [7:0]  wbAdr = 8'h00, memDelay = 8'h03;
  logic [3:0]  wbSel = 4'hF;
  logic [31:0] wbDatW = 32'h0, wbDatR;
  logic        ssyn, msyn, bbsy, sack, irq, nCycleIndicator;
  logic [15:0] dataWord = 16'h0;
  logic        cycleRequest = 0, singleCycle = 0, userAttention = 0;
  logic        powerFailLow = 0, parityError = 0, memSilent = 0;
  int          errTotal = 0, cmpCount = 0, n;
  logic [31:0] expQ[$];  // expected read data
  always #12.5 clk = ~clk;
  dbic_dma_ctrl #(.DEAD_CYCLES(DEAD)) u_dut (.clk(clk), .sys_rst(sysRst),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .ssyn(ssyn), .msyn(msyn),
    .bbsy(bbsy), .sack(sack), .irq(irq), .dataWord(dataWord), .cycleRequest(cycleRequest),
    .singleCycle(singleCycle), .userAttention(userAttention), .powerFailLow(powerFailLow),
    .parityError(parityError), .nCycleIndicator(nCycleIndicator));
  dbic_mem_model u_mem (.clk(clk), .sysRst(sysRst), .msyn(msyn), .ssyn(ssyn),
    .delay(memDelay), .silent(memSilent));
  // ****************************************
  // tasks
  // ****************************************
  // one classic cycle, held until ack sampled
  task wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= a; wbDatW <= d;
    // no own limit: only the watchdog ends a hung wait
    do @(posedge clk); while (wbAck !== 1'b1);
    wbCyc <= 1'b0; wbStb <= 1'b0;
    @(posedge clk);
  endtask
  task wbRd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    wbXfer(1'b0, a, 32'h0);
  endtask
  // wait for msyn (w=0) or bbsy (w=1) to reach a level
  task waitOn(input int w, input logic lvl, output int k);
    k = 0;
    while (((w == 0) ? msyn : bbsy) !== lvl && k < 2000) begin @(posedge clk); k++; end
  endtask
  // start one requested cycle, see the bus taken
  task askCycle();
    cycleRequest <= 1'b1;
    waitOn(0, 1'b1, n);
    cycleRequest <= 1'b0;
  endtask
  task summarize();
    $display("mismatches %0d, compares %0d", errTotal, cmpCount);
    if (errTotal == 0 && cmpCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // read data monitor: oldest note against ack data
  logic [31:0] expRd;  // oldest read note, popped once
  always @(posedge clk) begin
    if (wbAck === 1'b1 && wbWe === 1'b0 && expQ.size() > 0) begin
      expRd = expQ.pop_front();
      `CHK(wbDatR, expRd)
    end
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    summarize();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hA1EE));
    repeat (20) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    wbRd(ADR_MASK, 32'h1F);
    wbRd(ADR_STATUS, 32'h0);
    wbRd(8'h10, 32'h0);
    wbRd(ADR_LASTWORD, 32'h0);
    // plain cycle: last word latched
    dataWord <= 16'($urandom);
    wbXfer(1'b1, ADR_CONTROL, 32'h8003);
    askCycle();
    `CHK({bbsy, sack}, 2'b10)
    waitOn(1, 1'b0, n);
    wbRd(ADR_LASTWORD, {16'h0, dataWord});
    // absent memory, power and parity faults meanwhile
    memSilent <= 1'b1;
    wbXfer(1'b1, ADR_CONTROL, 32'h0003);
    askCycle();
    powerFailLow <= 1'b1; parityError <= 1'b1;
    repeat (4) @(posedge clk);
    powerFailLow <= 1'b0; parityError <= 1'b0;
    waitOn(0, 1'b0, n);
    `CHK(n >= NEX_CYCLES - 12 && n <= NEX_CYCLES, 1'b1)
    repeat (3) @(posedge clk);
    `CHK(bbsy, 1'b0)
    wbRd(ADR_STATUS, 32'h19);
    `CHK(irq, 1'b1)
    wbXfer(1'b1, ADR_MASK, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    wbXfer(1'b1, ADR_MASK, 32'h1F);
    wbXfer(1'b1, ADR_STATUS, 32'h01);
    wbRd(ADR_STATUS, 32'h18);
    memSilent <= 1'b0;
    wbXfer(1'b1, ADR_CONTROL, 32'h0003);
    wbRd(ADR_STATUS, 32'h0);
    // attention any time
    userAttention <= 1'b1;
    repeat (4) @(posedge clk);
    userAttention <= 1'b0;
    wbRd(ADR_STATUS, 32'h02);
    `CHK(irq, 1'b1)
    wbXfer(1'b1, ADR_STATUS, 32'h1F);
    // second request while a slow cycle runs
    memDelay <= 8'h1E;
    wbXfer(1'b1, ADR_CONTROL, 32'h0003);
    askCycle();
    repeat (3) @(posedge clk);
    cycleRequest <= 1'b1;
    repeat (4) @(posedge clk);
    cycleRequest <= 1'b0;
    waitOn(1, 1'b0, n);
    wbRd(ADR_STATUS, 32'h04);
    // N-cycle burst left hanging: dead-time frees bus
    memDelay <= 8'h02; singleCycle <= 1'b1;
    wbXfer(1'b1, ADR_CONTROL, 32'h0007);
    wbRd(ADR_STATUS, 32'h0);
    askCycle();
    `CHK({sack, nCycleIndicator}, 2'b11)
    waitOn(0, 1'b0, n);
    repeat (2) @(posedge clk);
    `CHK({bbsy, sack}, 2'b11)
    waitOn(1, 1'b0, n);
    `CHK(n >= DEAD - 6 && n <= DEAD + 3, 1'b1)
    `CHK(sack, 1'b0)
    // N-cycle then two-cycle, two cycles each
    for (int m = 0; m < 2; m++) begin
      wbXfer(1'b1, ADR_CONTROL, (m == 1) ? 32'h800F : 32'h8007);
      for (int c = 0; c < 2; c++) begin
        singleCycle <= (c == 0) || (m == 1);
        dataWord <= 16'($urandom);
        askCycle();
        `CHK({bbsy, sack, nCycleIndicator}, {1'b1, c == 0, m == 0})
        waitOn(0, 1'b0, n);
      end
      waitOn(1, 1'b0, n);
      `CHK(n < 4, 1'b1)
      wbRd(ADR_LASTWORD, {16'h0, dataWord});
    end
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule
`default_nettype wire
